// >>> src/pit_defines.svh
// Purpose: named codes, field positions and constants of the interval timer
// Assumes: included by bare name after pit_pkg is compiled
// Notes:   definitions only
`ifndef PIT_DEFINES_SVH
`define PIT_DEFINES_SVH
`define PIT_SEL_C0     2'h0
`define PIT_SEL_CTRL   2'h3
`define PIT_SC_RB      2'h3
`define PIT_FMT_LATCH  2'h0
`define PIT_FMT_LSB    2'h1
`define PIT_FMT_MSB    2'h2
`define PIT_FMT_WORD   2'h3
`define PIT_M0         3'h0
`define PIT_M1         3'h1
`define PIT_M2         3'h2
`define PIT_M3         3'h3
`define PIT_M4         3'h4
`define PIT_M5         3'h5
`define PIT_CW_SC      7:6
`define PIT_CT_ALL     5:0
`define PIT_CT_FMT     5:4
`define PIT_CT_MODE    3:1
`define PIT_CT_BCD     0
`define PIT_RB_NCNT    5
`define PIT_RB_NSTAT   4
`define PIT_RB_SEL0    1
`define PIT_ZERO       16'h0000
`define PIT_ONE        16'h0001
`define PIT_TWO        16'h0002
`define PIT_EVEN_MASK  16'hfffe
`define PIT_SYNC_INIT  19'h00007
`endif

// >>> src/pit_pkg.sv
// Purpose: types shared by the interval timer modules
// Assumes: nothing
// Notes:   pit_bus_t order fixes the synchroniser vector layout
package pit_pkg;
  typedef struct packed {
    logic [2:0]  gate;
    logic [2:0]  clk;
    logic [7:0]  data;
    logic [1:0]  sel;
    logic        wrN;
    logic        rdN;
    logic        csN;
  } pit_bus_t;
  typedef struct packed {
    logic [5:0]  ctrl;
    logic [15:0] countHold;
    logic [15:0] ce;
    logic [15:0] outLatch;
    logic [7:0]  stat;
    logic        olFull;
    logic        stFull;
    logic        nullCnt;
    logic        wrHi;
    logic        rdHi;
    logic        out;
    logic        gate;
    logic        trig;
    logic        trigS;
    logic        loadPend;
    logic        loaded;
    logic        armed;
    logic        cntOk;
    logic        oddWait;
  } pit_ch_t;
  typedef struct packed {
    logic [7:0]    dataOut;
    logic          dataOe;
    pit_ch_t [2:0] ch;
  } pit_st_t;
endpackage

// >>> src/pit_sync.sv
// Purpose: three-flop synchroniser with agreement filter and edge pulses
// Assumes: inputs asynchronous to sys_clk
// Notes:   a change counts once the second and third stages agree
`timescale 1ns/100ps
module pit_sync #(
  parameter int             W    = 1,
  parameter logic [W-1:0]   INIT = '0
) (
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } pit_sy_t;
  pit_sy_t      r;
  pit_sy_t      n;
  logic [W-1:0] agree;
  always_comb begin
    agree = ~(r.s2 ^ r.s3);
    n.s1 = d;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.q = (agree & r.s3) | (~agree & r.q);
    n.rise = agree & r.s3 & ~r.q;
    n.fall = agree & ~r.s3 & r.q;
  end
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r <= '{s1: INIT, s2: INIT, s3: INIT, q: INIT, rise: '0, fall: '0};
    end else begin
      r <= n;
    end
  end
  assign q = r.q;
  assign rise = r.rise;
  assign fall = r.fall;
endmodule

// >>> src/pit_dec.sv
// Purpose: decrement by one or two, binary or four-digit decimal
// Assumes: decimal input holds valid digits
// Notes:   both kinds wrap past zero; a step of one lands on the top value
`timescale 1ns/100ps
module pit_dec (
  input  wire logic [15:0] val,
  input  wire logic        bcd,
  input  wire logic        two,
  output logic      [15:0] res
);
  logic [3:0] brw;
  logic [3:0] dgt;
  always_comb begin
    brw = two ? 4'h2 : 4'h1;
    dgt = 4'h0;
    res = val - {14'h0000, two, ~two};
    if (bcd) begin
      for (int k = 0; k < 4; k++) begin
        dgt = val[4*k +: 4];
        if (dgt >= brw) begin
          res[4*k +: 4] = dgt - brw;
          brw = 4'h0;
        end else begin
          res[4*k +: 4] = dgt + 4'ha - brw;
          brw = 4'h1;
        end
      end
    end
  end
endmodule

// >>> src/pit_timer.sv
// Function
// - Control or full count write sets pending flag
// - First status latch kept until read
// - Zero bits latch count and status together
// - Status read first, then count bytes
// - Address decode, undriven bus otherwise
// - Pulse is rise then fall; trigger rise
// - Mode 0 output low until zero
// - Mode 0 gate gates counting; N+1 pulses
// - Mode 0 first byte halts, output low
// - Mode 0 loads even with gate low
// - Mode 1 trigger loads, output low N
// - Mode 1 new count waits for retrigger
// - Mode 2 low one pulse at one
// - Mode 2 gate low forces output high
// - Mode 2 new count waits period end
// - Mode 3 square wave, step two
// - Mode 3 gate low forces output high
// - Mode 3 new count at half-cycle end
// - Mode 4 strobe N+1 pulses after write
// - Mode 4 first byte has no effect
// - Mode 5 trigger starts strobe sequence
// - Mode 5 retrigger loads new count
// - Loads and decrements on falling edge
// - Gate sampled on rise; trigger flop
// - Control word resets channel at once
// - Modes 0,1,4,5 wrap past zero
//
// Purpose: three-channel 16-bit interval timer behind an 8-bit host port
// Assumes: pin rates well below sys_clk divided by six
// Notes:   all edges are found on sys_clk after three-flop filtering
`timescale 1ns/100ps
`include "pit_defines.svh"
module pit_timer (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       csN,
  input  wire logic       rdN,
  input  wire logic       wrN,
  input  wire logic [1:0] regSel,
  input  wire logic [7:0] dataIn,
  output logic      [7:0] dataOut,
  output logic            dataOe,
  input  wire logic [2:0] cntClk,
  input  wire logic [2:0] cntGate,
  output logic      [2:0] cntOut
);
  localparam int NCH = 3;

  pit_pkg::pit_bus_t    rawBus;
  pit_pkg::pit_bus_t    bq;
  pit_pkg::pit_bus_t    bRise;
  pit_pkg::pit_bus_t    bFall;
  pit_pkg::pit_st_t     r;
  pit_pkg::pit_st_t     n;
  pit_pkg::pit_ch_t     c;
  logic [NCH-1:0][15:0] decVal;
  logic [2:0]           m;
  logic [2:0]           nm;
  logic [1:0]           f;
  logic                 doneW;
  logic                 tr;
  logic                 wrDone;
  logic                 rdDone;

  function automatic logic [2:0] normMode(input logic [2:0] v);
    // Upper codes of the two periodic modes alias onto them
    return v[1] ? {1'b0, v[1:0]} : v;
  endfunction

  function automatic pit_pkg::pit_ch_t loadCe(input pit_pkg::pit_ch_t x,
                                              input logic [15:0]     v);
    x.ce = v;
    x.loadPend = 1'b0;
    x.nullCnt = 1'b0;
    x.loaded = 1'b1;
    x.armed = 1'b1;
    return x;
  endfunction

  function automatic pit_pkg::pit_ch_t latchCnt(input pit_pkg::pit_ch_t x);
    if (!x.olFull) begin
      x.outLatch = x.ce;
      x.olFull = 1'b1;
    end
    return x;
  endfunction

  function automatic pit_pkg::pit_ch_t latchSt(input pit_pkg::pit_ch_t x);
    if (!x.stFull) begin
      x.stat = {x.out, x.nullCnt, x.ctrl};
      x.stFull = 1'b1;
    end
    return x;
  endfunction

  function automatic logic [7:0] rdByte(input pit_pkg::pit_ch_t x);
    logic [15:0] src;
    src = x.olFull ? x.outLatch : x.ce;
    if (x.stFull) begin
      return x.stat;
    end
    if (x.ctrl[`PIT_CT_FMT] == `PIT_FMT_MSB ||
        (x.ctrl[`PIT_CT_FMT] == `PIT_FMT_WORD && x.rdHi)) begin
      return src[15:8];
    end
    return src[7:0];
  endfunction

  assign rawBus = '{gate: cntGate, clk: cntClk, data: dataIn, sel: regSel,
                    wrN: wrN, rdN: rdN, csN: csN};

  pit_sync #(
    .W    ($bits(pit_pkg::pit_bus_t)),
    .INIT (`PIT_SYNC_INIT)
  ) uSync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .d       (rawBus),
    .q       (bq),
    .rise    (bRise),
    .fall    (bFall)
  );

  for (genvar g = 0; g < NCH; g++) begin : gCh
    pit_dec uDec (
      .val (r.ch[g].ce),
      .bcd (r.ch[g].ctrl[`PIT_CT_BCD]),
      .two (normMode(r.ch[g].ctrl[`PIT_CT_MODE]) == `PIT_M3),
      .res (decVal[g])
    );
    assign cntOut[g] = r.ch[g].out;
  end

  // Access ends on the strobe's rising edge, after data has settled
  assign wrDone = bRise.wrN && !bq.csN;
  assign rdDone = bRise.rdN && !bq.csN && bq.sel != `PIT_SEL_CTRL;

  always_comb begin
    n = r;
    c = r.ch[0];
    m = `PIT_M0;
    nm = `PIT_M0;
    f = `PIT_FMT_LATCH;
    doneW = 1'b0;
    tr = 1'b0;
    // drive only on a counter read
    n.dataOe = !bq.csN && !bq.rdN && bq.wrN && bq.sel != `PIT_SEL_CTRL;
    n.dataOut = 8'h00;
    for (int i = 0; i < NCH; i++) begin
      c = r.ch[i];
      m = normMode(c.ctrl[`PIT_CT_MODE]);
      f = c.ctrl[`PIT_CT_FMT];
      doneW = 1'b0;
      tr = c.trigS && c.cntOk;
      if (bRise.clk[i]) begin
        c.gate = bq.gate[i];
        c.trigS = c.trig | bRise.gate[i];
        c.trig = 1'b0;
      end else if (bRise.gate[i]) begin
        c.trig = 1'b1;
      end
      if (bFall.clk[i]) begin
        c.trigS = 1'b0;
        if (m == `PIT_M4 || m == `PIT_M5) begin
          c.out = 1'b1;
        end
        case (m)
          `PIT_M0: begin
            if (c.loadPend) begin
              c = loadCe(c, c.countHold);
            end else if (c.gate && !(c.wrHi && f == `PIT_FMT_WORD)) begin
              c.ce = decVal[i];
              if (decVal[i] == `PIT_ZERO && c.armed) begin
                c.out = 1'b1;
                c.armed = 1'b0;
              end
            end
          end
          `PIT_M1: begin
            if (tr) begin
              c = loadCe(c, c.countHold);
              c.out = 1'b0;
            end else if (c.loaded) begin
              c.ce = decVal[i];
              if (decVal[i] == `PIT_ZERO && c.armed) begin
                c.out = 1'b1;
                c.armed = 1'b0;
              end
            end
          end
          `PIT_M2: begin
            if (tr || c.loadPend) begin
              c = loadCe(c, c.countHold);
              c.out = 1'b1;
            end else if (c.gate && c.loaded) begin
              if (c.ce == `PIT_ONE) begin
                c = loadCe(c, c.countHold);
                c.out = 1'b1;
              end else begin
                c.ce = decVal[i];
                c.out = decVal[i] != `PIT_ONE;
              end
            end
          end
          `PIT_M3: begin
            if (tr || c.loadPend) begin
              c = loadCe(c, c.countHold & `PIT_EVEN_MASK);
              c.out = 1'b1;
              c.oddWait = 1'b0;
            end else if (c.gate && c.loaded) begin
              if (c.oddWait) begin
                c = loadCe(c, c.countHold & `PIT_EVEN_MASK);
                c.out = 1'b0;
                c.oddWait = 1'b0;
              end else if (c.ce == `PIT_TWO) begin
                // Odd counts stretch the high half by one pulse
                if (c.out && c.countHold[0]) begin
                  c.ce = `PIT_ZERO;
                  c.oddWait = 1'b1;
                end else begin
                  c = loadCe(c, c.countHold & `PIT_EVEN_MASK);
                  c.out = !c.out;
                end
              end else begin
                c.ce = decVal[i];
              end
            end
          end
          `PIT_M4: begin
            if (c.loadPend) begin
              c = loadCe(c, c.countHold);
            end else if (c.gate && c.loaded) begin
              c.ce = decVal[i];
              if (decVal[i] == `PIT_ZERO && c.armed) begin
                c.out = 1'b0;
                c.armed = 1'b0;
              end
            end
          end
          `PIT_M5: begin
            if (tr) begin
              c = loadCe(c, c.countHold);
            end else if (c.loaded) begin
              c.ce = decVal[i];
              if (decVal[i] == `PIT_ZERO && c.armed) begin
                c.out = 1'b0;
                c.armed = 1'b0;
              end
            end
          end
          default: begin
          end
        endcase
      end
      if ((m == `PIT_M2 || m == `PIT_M3) && !bq.gate[i]) begin
        c.out = 1'b1;
      end
      if (wrDone && bq.sel == `PIT_SEL_CTRL) begin
        nm = normMode(bq.data[`PIT_CT_MODE]);
        if (bq.data[`PIT_CW_SC] == `PIT_SC_RB) begin
          if (bq.data[`PIT_RB_SEL0 + i]) begin
            if (!bq.data[`PIT_RB_NCNT]) begin
              c = latchCnt(c);
            end
            if (!bq.data[`PIT_RB_NSTAT]) begin
              c = latchSt(c);
            end
          end
        end else if (bq.data[`PIT_CW_SC] == 2'(i)) begin
          if (bq.data[`PIT_CT_FMT] == `PIT_FMT_LATCH) begin
            c = latchCnt(c);
          end else begin
            c.ctrl = bq.data[`PIT_CT_ALL];
            c.nullCnt = 1'b1;
            c.out = nm != `PIT_M0;
            c.loadPend = 1'b0;
            c.loaded = 1'b0;
            c.armed = 1'b0;
            c.cntOk = 1'b0;
            c.wrHi = 1'b0;
            c.rdHi = 1'b0;
            c.olFull = 1'b0;
            c.stFull = 1'b0;
            c.oddWait = 1'b0;
            c.trig = 1'b0;
            c.trigS = 1'b0;
          end
        end
      end else if (wrDone && bq.sel == 2'(i)) begin
        case (f)
          `PIT_FMT_LSB: begin
            c.countHold = {8'h00, bq.data};
            doneW = 1'b1;
          end
          `PIT_FMT_MSB: begin
            c.countHold = {bq.data, 8'h00};
            doneW = 1'b1;
          end
          `PIT_FMT_WORD: begin
            if (!c.wrHi) begin
              c.countHold[7:0] = bq.data;
              c.wrHi = 1'b1;
              // first byte: halt only in mode 0
              if (m == `PIT_M0) begin
                c.out = 1'b0;
                c.loadPend = 1'b0;
              end
            end else begin
              c.countHold[15:8] = bq.data;
              c.wrHi = 1'b0;
              doneW = 1'b1;
            end
          end
          default: begin
          end
        endcase
        if (doneW) begin
          c.nullCnt = 1'b1;
          c.cntOk = 1'b1;
          case (m)
            `PIT_M0: begin
              c.out = 1'b0;
              c.loadPend = 1'b1;
            end
            `PIT_M2, `PIT_M3: begin
              c.loadPend = !c.loaded;
            end
            `PIT_M4: begin
              c.loadPend = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      // status, then latched count, then live
      if (rdDone && bq.sel == 2'(i)) begin
        if (c.stFull) begin
          c.stFull = 1'b0;
        end else if (f == `PIT_FMT_WORD && !c.rdHi) begin
          c.rdHi = 1'b1;
        end else begin
          c.rdHi = 1'b0;
          c.olFull = 1'b0;
        end
      end
      if (bq.sel == 2'(i)) begin
        n.dataOut = rdByte(r.ch[i]);
      end
      n.ch[i] = c;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign dataOut = r.dataOut;
  assign dataOe = r.dataOe;

  logic [2:0] mode0;
  logic [2:0] mode1;
  logic       cw0;
  logic       rd0;
  assign mode0 = normMode(r.ch[0].ctrl[`PIT_CT_MODE]);
  // Channel 1 carries the bench's rate generator
  assign mode1 = normMode(r.ch[1].ctrl[`PIT_CT_MODE]);
  assign cw0 = wrDone && bq.sel == `PIT_SEL_CTRL && bq.data[`PIT_CW_SC] == `PIT_SEL_C0 &&
               bq.data[`PIT_CT_FMT] != `PIT_FMT_LATCH;
  assign rd0 = rdDone && bq.sel == `PIT_SEL_C0;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  AST_NULL_SET:
    assert property (cw0 |=> r.ch[0].nullCnt && !r.ch[0].loadPend)
    else $error("pending-load flag not set by control word");
  AST_NULL_CLR:
    assert property (mode0 == `PIT_M0 && r.ch[0].loadPend && bFall.clk[0] && !wrDone
                     |=> !r.ch[0].nullCnt && r.ch[0].ce == $past(r.ch[0].countHold))
    else $error("load did not clear pending flag");
  AST_ST_KEEP:
    assert property (r.ch[0].stFull && !rd0 && !cw0
                     |=> r.ch[0].stFull && $stable(r.ch[0].stat))
    else $error("latched status changed before read");
  AST_OL_KEEP:
    assert property (r.ch[0].olFull && !rd0 |=> $stable(r.ch[0].outLatch))
    else $error("latched count changed before read");
  AST_ST_FIRST:
    assert property (r.ch[0].stFull && bq.sel == `PIT_SEL_C0
                     |=> dataOut == $past(r.ch[0].stat))
    else $error("status not returned first");
  AST_FLOAT:
    assert property (bq.csN || bq.rdN || bq.sel == `PIT_SEL_CTRL |=> !dataOe)
    else $error("bus driven outside a counter read");
  AST_M0_LOW:
    assert property (cw0 && normMode(bq.data[`PIT_CT_MODE]) == `PIT_M0 |=> !cntOut[0])
    else $error("mode 0 output not low after control word");
  AST_M0_RISE:
    assert property (mode0 == `PIT_M0 && r.ch[0].armed && bFall.clk[0] && r.ch[0].gate &&
                     decVal[0] == `PIT_ZERO && !r.ch[0].loadPend && !r.ch[0].wrHi &&
                     !wrDone |=> cntOut[0] && !r.ch[0].armed)
    else $error("mode 0 output did not rise at zero");
  AST_GATE_HIGH:
    assert property ((mode1 == `PIT_M2 || mode1 == `PIT_M3) && !bq.gate[1] && !wrDone
                     |=> cntOut[1])
    else $error("gate low did not force output high");
  AST_STROBE_1:
    assert property (mode0 == `PIT_M4 && !cntOut[0] && bFall.clk[0] && !wrDone
                     |=> cntOut[0])
    else $error("strobe longer than one pulse");

  COV_M0_RISE: cover property (mode0 == `PIT_M0 ##1 $rose(cntOut[0]));
  COV_BOTH: cover property (r.ch[0].stFull && r.ch[0].olFull);
  COV_M3_FALL: cover property (normMode(r.ch[2].ctrl[`PIT_CT_MODE]) == `PIT_M3 &&
                               $fell(cntOut[2]));
endmodule

// >>> sim/pit_host.sv
// Purpose: host processor model on the timer's 8-bit port
// Assumes: strobes held 8 sys_clk cycles on each side of every edge
// Notes:   once released, the data lines show the inverse of the last byte
`timescale 1ns/100ps
module pit_host (
  input  wire logic       sys_clk,
  output logic            csN,
  output logic            rdN,
  output logic            wrN,
  output logic      [1:0] regSel,
  output logic      [7:0] dataIn,
  input  wire logic [7:0] dataOut,
  input  wire logic       dataOe
);
  initial begin
    csN = 1'b1;
    rdN = 1'b1;
    wrN = 1'b1;
    regSel = 2'h0;
    dataIn = 8'h00;
  end

  // Register write cycle; rateGen uses it to load a mode 2 count
  task automatic wr(input logic [1:0] sel, input logic [7:0] d);
    @(posedge sys_clk);
    csN    <= 1'b0;
    wrN    <= 1'b0;
    regSel <= sel;
    dataIn <= d;
    repeat (8) @(posedge sys_clk);
    wrN <= 1'b1;
    // Address and data stay past the filtered rise
    repeat (8) @(posedge sys_clk);
    csN    <= 1'b1;
    dataIn <= ~d;
  endtask

  task automatic rd(input logic [1:0] sel, input logic cs, output logic [7:0] d,
                    output logic oe);
    @(posedge sys_clk);
    csN    <= cs;
    rdN    <= 1'b0;
    regSel <= sel;
    repeat (8) @(posedge sys_clk);
    d   = dataOut;
    oe  = dataOe;
    rdN <= 1'b1;
    repeat (8) @(posedge sys_clk);
    csN <= 1'b1;
  endtask
endmodule

// >>> sim/testbench.sv
// Purpose: self-checking bench for the three-channel interval timer
// Assumes: counter clocks and gates far slower than sys_clk
// Notes:   each clock, gate and strobe level is held 8 cycles so the filters always settle
`timescale 1ns/100ps
module testbench;
  logic       sys_clk;
  logic       srst;
  logic       csN;
  logic       rdN;
  logic       wrN;
  logic [1:0] regSel;
  logic [7:0] dataIn;
  logic [7:0] dataOut;
  logic       dataOe;
  logic [2:0] cntClk;
  logic [2:0] cntGate;
  logic [2:0] cntOut;
  logic [7:0] rdData;
  logic       rdOe;
  int         nErrors = 0;
  int         checksDone = 0;

  pit_timer i_dut (.sys_clk(sys_clk), .srst(srst), .csN(csN), .rdN(rdN), .wrN(wrN),
                   .regSel(regSel), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe),
                   .cntClk(cntClk), .cntGate(cntGate), .cntOut(cntOut));
  pit_host i_host (.sys_clk(sys_clk), .csN(csN), .rdN(rdN), .wrN(wrN), .regSel(regSel),
                   .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic conclude;
    if (nErrors == 0 && checksDone > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdChk(input logic [1:0] sel, input logic [7:0] exp, input string what);
    i_host.rd(sel, 1'b0, rdData, rdOe);
    chk(what, exp, rdData);
  endtask

  task automatic outChk(input int ch, input logic exp, input string what);
    chk(what, {7'h00, exp}, {7'h00, cntOut[ch]});
  endtask

  // Output is judged once the fall has passed the filter
  task automatic pulses(input int ch, input int n, input logic [15:0] bits, input string what);
    for (int i = 0; i < n; i++) begin
      cntClk[ch] <= 1'b1;
      repeat (8) @(posedge sys_clk);
      cntClk[ch] <= 1'b0;
      repeat (8) @(posedge sys_clk);
      outChk(ch, bits[i], what);
    end
  endtask

  task automatic trig(input int ch);
    cntGate[ch] <= 1'b0;
    repeat (8) @(posedge sys_clk);
    cntGate[ch] <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic modeZero;
    i_host.wr(2'h3, 8'h10);
    outChk(0, 1'b0, "m0 out after control");
    i_host.wr(2'h0, 8'h03);
    i_host.wr(2'h3, 8'he2);
    rdChk(2'h0, 8'h50, "m0 status pending");
    pulses(0, 4, 16'h0008, "m0 terminal count");
    pulses(0, 2, 16'h0003, "m0 out holds");
    i_host.wr(2'h3, 8'he2);
    rdChk(2'h0, 8'h90, "m0 status loaded");
  endtask

  task automatic latchOrder;
    i_host.wr(2'h3, 8'h30);
    outChk(0, 1'b0, "m0 control word drops out");
    i_host.wr(2'h0, 8'h05);
    i_host.wr(2'h0, 8'h01);
    i_host.wr(2'h3, 8'he2);
    pulses(0, 1, 16'h0000, "latch load pulse");
    i_host.wr(2'h3, 8'hc2);
    pulses(0, 2, 16'h0000, "latch count on");
    i_host.wr(2'h3, 8'hc2);
    rdChk(2'h0, 8'h70, "first status kept");
    rdChk(2'h0, 8'h05, "latched low byte");
    rdChk(2'h0, 8'h01, "latched high byte");
    rdChk(2'h0, 8'h03, "live low byte");
    rdChk(2'h0, 8'h01, "live high byte");
  endtask

  task automatic decode;
    i_host.rd(2'h3, 1'b0, rdData, rdOe);
    chk("oe at control address", 8'h00, {7'h00, rdOe});
    i_host.rd(2'h0, 1'b1, rdData, rdOe);
    chk("oe deselected", 8'h00, {7'h00, rdOe});
    i_host.rd(2'h1, 1'b0, rdData, rdOe);
    chk("oe counter read", 8'h01, {7'h00, rdOe});
  endtask

  task automatic rateGen;
    i_host.wr(2'h3, 8'h54);
    i_host.wr(2'h1, 8'h03);
    pulses(1, 4, 16'h000b, "m2 first period");
    pulses(1, 3, 16'h0005, "m2 reload period");
    pulses(1, 2, 16'h0001, "m2 low pulse");
    cntGate[1] <= 1'b0;
    repeat (8) @(posedge sys_clk);
    outChk(1, 1'b1, "m2 gate low forces high");
    cntGate[1] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    pulses(1, 3, 16'h0003, "m2 trigger reload");
  endtask

  task automatic squareWave;
    i_host.wr(2'h3, 8'h96);
    i_host.wr(2'h2, 8'h05);
    pulses(2, 10, 16'h00e7, "m3 odd square");
    cntGate[2] <= 1'b0;
    repeat (8) @(posedge sys_clk);
    outChk(2, 1'b1, "m3 gate low forces high");
    cntGate[2] <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask

  task automatic oneShot;
    i_host.wr(2'h3, 8'h52);
    outChk(1, 1'b1, "m1 initial high");
    i_host.wr(2'h1, 8'h02);
    pulses(1, 1, 16'h0001, "m1 armed no trigger");
    trig(1);
    pulses(1, 3, 16'h0004, "m1 one shot");
    trig(1);
    pulses(1, 1, 16'h0000, "m1 second shot");
    i_host.wr(2'h1, 8'h04);
    pulses(1, 2, 16'h0002, "m1 write keeps shot");
    trig(1);
    pulses(1, 5, 16'h0010, "m1 retrigger new count");
  endtask

  task automatic hwStrobe;
    i_host.wr(2'h3, 8'h9a);
    i_host.wr(2'h2, 8'h02);
    pulses(2, 1, 16'h0001, "m5 waits trigger");
    trig(2);
    pulses(2, 4, 16'h000b, "m5 strobe");
  endtask

  task automatic swStrobe;
    i_host.wr(2'h3, 8'h18);
    i_host.wr(2'h0, 8'h02);
    pulses(0, 4, 16'h000b, "m4 strobe");
  endtask

  task automatic twoByte;
    i_host.wr(2'h3, 8'h30);
    outChk(0, 1'b0, "m0 low after control");
    i_host.wr(2'h0, 8'h01);
    i_host.wr(2'h0, 8'h00);
    pulses(0, 2, 16'h0002, "m0 count one");
    i_host.wr(2'h0, 8'h02);
    outChk(0, 1'b0, "m0 first byte low");
    cntGate[0] <= 1'b0;
    repeat (8) @(posedge sys_clk);
    i_host.wr(2'h0, 8'h00);
    pulses(0, 3, 16'h0000, "m0 gate low load");
    cntGate[0] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    pulses(0, 2, 16'h0002, "m0 gate high count");
    i_host.wr(2'h3, 8'h38);
    i_host.wr(2'h0, 8'h03);
    i_host.wr(2'h0, 8'h00);
    pulses(0, 2, 16'h0003, "m4 before first byte");
    i_host.wr(2'h0, 8'h05);
    pulses(0, 2, 16'h0001, "m4 first byte no effect");
    i_host.wr(2'h0, 8'h00);
    pulses(0, 6, 16'h001f, "m4 second byte restarts");
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    nErrors++;
    conclude();
  end

  initial begin
    srst = 1'b1;
    cntClk = 3'h0;
    cntGate = 3'h7;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    modeZero();
    latchOrder();
    decode();
    rateGen();
    squareWave();
    oneShot();
    hwStrobe();
    swStrobe();
    twoByte();
    conclude();
  end
endmodule
